// ==== core/tpw_timer.sv ====
// 8-bit timer with phase correct pwm, flags, prescaler reset and wishbone registers
// Notes on behaviour
// - phase correct operation when waveform mode select equals 1.
// - counter counts bottom up to max, then back down to bottom.
// - non-inverting clears on up-count match, sets on down-count match; inverting opposite.
// - pwm resolution is always eight bits.
// - counter holds max for one timer tick, then reverses.
// - overflow flag sets when counter reaches bottom and turns.
// - output mode two gives non-inverted pwm, three inverted.
// - compare level reaches the pin only when direction bit selects output.
// - flag register bits 7:2 read zero.
// - compare match flag, bit 1, sets when count equals compare value.
// - flags clear on interrupt vector acknowledge or software write of one.
// - compare irq needs global enable, compare enable and compare flag.
// - overflow flag is bit 0; irq needs global, overflow enable and flag.
// - writing one to prescaler reset bit resets prescaler; bit self-clears.
// - in asynchronous mode the reset bit stays one until reset completes.
// - prescaler reset bit never self-clears while sync hold mode is set.
// - counter max is 0xff.
// - output mode zero: no compare action, pin keeps port function.
// - new output mode takes effect at next compare match.
//
// Our own choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "tpw_cfg.svh"
module tpw_timer #(
    parameter int PS_WIDTH = 10
) (
    // clock and reset
    input  wire logic        i_clock,
    input  wire logic        i_reset,
    // wishbone slave
    input  wire logic        i_wb_cyc,
    input  wire logic        i_wb_stb,
    input  wire logic        i_wb_we,
    input  wire logic [7:0]  i_wb_adr,
    input  wire logic [3:0]  i_wb_sel,
    input  wire logic [31:0] i_wb_dat,
    output logic [31:0]      o_wb_dat,
    output logic             o_wb_ack,
    // port pin and general port function
    input  wire logic        i_port_value,
    output logic             o_compare_out_pin,
    output logic             o_compare_out_pin_oe,
    // interrupt requests to the cpu
    output logic             o_compare_irq,
    output logic             o_overflow_irq
);
    typedef struct packed {
        logic [31:0]        rdata;
        logic               ack;
        logic [7:0]         count_value;
        logic [7:0]         compare_value;
        tpw_pkg::tpw_dir_t  dir;
        logic [1:0]         waveform_mode_sel;
        logic [1:0]         compare_output_mode;
        logic [1:0]         active_com;
        logic               port_dir_out;
        logic               global_irq_enable;
        logic               async_mode;
        logic [2:0]         clock_select;
        logic               compare_out;
        logic               overflow_flag;
        logic               compare_match_flag;
        logic               compare_irq_enable;
        logic               overflow_irq_enable;
        logic               prescaler_reset_bit;
        logic               sync_hold_mode;
        logic [1:0]         psr_wait;
        logic               pin;
        logic               pin_oe;
        logic               cirq;
        logic               oirq;
    } tpw_state_t;

    tpw_state_t state_q;
    tpw_state_t state_d;
    logic       access;
    logic       tick;
    logic       wr;
    logic       psr_clear;

    initial begin
        if (PS_WIDTH < 10 || PS_WIDTH > 16) begin
            $error("prescaler width must be 10 to 16");
        end
    end

    function automatic logic [31:0] lanes(input logic [31:0] old, input logic [31:0] nw,
                                          input logic [3:0] sel);
        lanes = old;
        for (int i = 0; i < 4; i++) begin
            if (sel[i]) begin
                lanes[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
    endfunction

    tpw_wb_slave u_bus (
        .i_clock  (i_clock),
        .i_reset  (i_reset),
        .i_cyc    (i_wb_cyc),
        .i_stb    (i_wb_stb),
        .o_access (access),
        .o_ack    ()
    );

    // prescaler cleared while the reset bit is one
    assign psr_clear = state_q.prescaler_reset_bit;

    tpw_prescaler #(
        .WIDTH (PS_WIDTH)
    ) u_ps (
        .i_clock  (i_clock),
        .i_reset  (i_reset),
        .i_clear  (psr_clear),
        .i_select (state_q.clock_select),
        .o_tick   (tick)
    );

    assign wr = access && i_wb_we;

    always_comb begin
        logic [31:0] w;
        logic        up_match;
        logic        dn_match;
        logic        hit;
        logic        bottom;
        logic        set_ovf;
        logic        set_cmp;
        w        = '0;
        up_match = 1'b0;
        dn_match = 1'b0;
        hit      = 1'b0;
        bottom   = 1'b0;
        set_ovf  = 1'b0;
        set_cmp  = 1'b0;
        state_d  = state_q;
        state_d.ack = access;

        // dual slope counting on each timer tick
        if (tick && state_q.waveform_mode_sel == `TPW_WGM_PHASE) begin
            hit = (state_q.count_value == state_q.compare_value);
            if (state_q.dir == tpw_pkg::TPW_DIR_UP) begin
                up_match = hit;
                if (state_q.count_value == `TPW_COUNT_MAX) begin
                    // max held one tick, then turn down
                    state_d.dir         = tpw_pkg::TPW_DIR_DOWN;
                    state_d.count_value = state_q.count_value - 8'h01;
                end else begin
                    state_d.count_value = state_q.count_value + 8'h01;
                end
            end else begin
                dn_match = hit;
                if (state_q.count_value == `TPW_COUNT_BOTTOM) begin
                    state_d.dir         = tpw_pkg::TPW_DIR_UP;
                    state_d.count_value = state_q.count_value + 8'h01;
                    bottom              = 1'b1;
                end else begin
                    state_d.count_value = state_q.count_value - 8'h01;
                end
            end
            set_cmp = hit;
            set_ovf = bottom;
            if (hit) begin
                state_d.active_com = state_q.compare_output_mode;
                case (state_q.compare_output_mode)
                    `TPW_COM_NONINV: state_d.compare_out = dn_match && !up_match;
                    `TPW_COM_INV:    state_d.compare_out = up_match && !dn_match;
                    default:         state_d.compare_out = state_q.compare_out;
                endcase
            end
        end

        // prescaler reset bit: self-clear unless hold mode or async wait
        if (state_q.prescaler_reset_bit && !state_q.sync_hold_mode) begin
            if (!state_q.async_mode) begin
                state_d.prescaler_reset_bit = 1'b0;
            end else if (state_q.psr_wait == 2'(`TPW_ASYNC_PSR_CYCLES - 1)) begin
                state_d.prescaler_reset_bit = 1'b0;
                state_d.psr_wait            = 2'h0;
            end else begin
                state_d.psr_wait = state_q.psr_wait + 2'h1;
            end
        end

        // register writes
        if (wr) begin
            case (i_wb_adr)
                `TPW_ADDR_CTRL: begin
                    w = lanes({16'h0, 5'h0, state_q.clock_select, 1'b0,
                               state_q.async_mode, state_q.global_irq_enable,
                               state_q.port_dir_out, state_q.compare_output_mode,
                               state_q.waveform_mode_sel}, i_wb_dat, i_wb_sel);
                    state_d.waveform_mode_sel   = w[`TPW_CTRL_WGM_LSB +: 2];
                    state_d.compare_output_mode = w[`TPW_CTRL_COM_LSB +: 2];
                    state_d.port_dir_out        = w[`TPW_CTRL_DDR_BIT];
                    state_d.global_irq_enable   = w[`TPW_CTRL_GIE_BIT];
                    state_d.async_mode          = w[`TPW_CTRL_ASYNC_BIT];
                    state_d.clock_select        = w[`TPW_CTRL_PS_LSB +: 3];
                end
                `TPW_ADDR_COUNT: begin
                    if (i_wb_sel[0]) begin
                        state_d.count_value = i_wb_dat[7:0];
                    end
                end
                `TPW_ADDR_COMPARE: begin
                    if (i_wb_sel[0]) begin
                        state_d.compare_value = i_wb_dat[7:0];
                    end
                end
                `TPW_ADDR_FLAGS: begin
                    if (i_wb_sel[0] && i_wb_dat[`TPW_FLAG_OVF_BIT]) begin
                        state_d.overflow_flag = 1'b0;
                    end
                    if (i_wb_sel[0] && i_wb_dat[`TPW_FLAG_CMP_BIT]) begin
                        state_d.compare_match_flag = 1'b0;
                    end
                end
                `TPW_ADDR_IRQEN: begin
                    if (i_wb_sel[0]) begin
                        state_d.overflow_irq_enable = i_wb_dat[`TPW_IRQEN_OVF_BIT];
                        state_d.compare_irq_enable  = i_wb_dat[`TPW_IRQEN_CMP_BIT];
                    end
                end
                `TPW_ADDR_GTC: begin
                    if (i_wb_sel[0]) begin
                        state_d.sync_hold_mode = i_wb_dat[`TPW_GTC_TSM_BIT];
                        if (i_wb_dat[`TPW_GTC_PSR_BIT]) begin
                            state_d.prescaler_reset_bit = 1'b1;
                            state_d.psr_wait            = 2'h0;
                        end
                    end
                end
                `TPW_ADDR_IRQACK: begin
                    // vector execution acknowledge from the cpu
                    if (i_wb_sel[0] && i_wb_dat[`TPW_FLAG_OVF_BIT]) begin
                        state_d.overflow_flag = 1'b0;
                    end
                    if (i_wb_sel[0] && i_wb_dat[`TPW_FLAG_CMP_BIT]) begin
                        state_d.compare_match_flag = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // hardware set after clears so the set wins
        if (set_ovf) begin
            state_d.overflow_flag = 1'b1;
        end
        if (set_cmp) begin
            state_d.compare_match_flag = 1'b1;
        end

        // read data
        state_d.rdata = state_q.rdata;
        if (access && !i_wb_we) begin
            case (i_wb_adr)
                `TPW_ADDR_CTRL: state_d.rdata = {16'h0, 5'h0, state_q.clock_select, 1'b0,
                                                 state_q.async_mode,
                                                 state_q.global_irq_enable,
                                                 state_q.port_dir_out,
                                                 state_q.compare_output_mode,
                                                 state_q.waveform_mode_sel};
                `TPW_ADDR_COUNT:   state_d.rdata = {24'h0, state_q.count_value};
                `TPW_ADDR_COMPARE: state_d.rdata = {24'h0, state_q.compare_value};
                `TPW_ADDR_FLAGS:   state_d.rdata = {24'h0, 6'h00,
                                                    state_q.compare_match_flag,
                                                    state_q.overflow_flag};
                `TPW_ADDR_IRQEN:   state_d.rdata = {24'h0, 6'h00,
                                                    state_q.compare_irq_enable,
                                                    state_q.overflow_irq_enable};
                `TPW_ADDR_GTC:     state_d.rdata = {24'h0, state_q.sync_hold_mode, 5'h00,
                                                    state_q.prescaler_reset_bit, 1'b0};
                default:           state_d.rdata = 32'h0000_0000;
            endcase
        end

        // pin: override only when a mode is active and direction is output
        state_d.pin_oe = state_q.port_dir_out;
        state_d.pin    = (state_q.active_com == `TPW_COM_OFF) ? i_port_value
                                                              : state_q.compare_out;
        state_d.cirq = state_q.global_irq_enable && state_q.compare_irq_enable
                       && state_q.compare_match_flag;
        state_d.oirq = state_q.global_irq_enable && state_q.overflow_irq_enable
                       && state_q.overflow_flag;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q     <= '0;
            state_q.dir <= tpw_pkg::TPW_DIR_UP;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_wb_dat             = state_q.rdata;
    assign o_wb_ack             = state_q.ack;
    assign o_compare_out_pin    = state_q.pin;
    assign o_compare_out_pin_oe = state_q.pin_oe;
    assign o_compare_irq        = state_q.cirq;
    assign o_overflow_irq       = state_q.oirq;
endmodule

// ==== pkg/tpw_cfg.svh ====
// register offsets, field positions, mode codes and timing counts for the pwm timer
`ifndef TPW_CFG_SVH
`define TPW_CFG_SVH
`define TPW_OFF_CTRL      4'h0
`define TPW_OFF_COUNT     4'h4
`define TPW_OFF_COMPARE   4'h8
`define TPW_OFF_FLAGS     4'hc
`define TPW_OFF_MASK      4'h0
`define TPW_OFF_GTC       4'h0
`define TPW_ADDR_CTRL     8'h00
`define TPW_ADDR_COUNT    8'h04
`define TPW_ADDR_COMPARE  8'h08
`define TPW_ADDR_FLAGS    8'h0c
`define TPW_ADDR_IRQEN    8'h10
`define TPW_ADDR_GTC      8'h14
`define TPW_ADDR_IRQACK   8'h18
`define TPW_CTRL_WGM_LSB  0
`define TPW_CTRL_COM_LSB  2
`define TPW_CTRL_DDR_BIT  4
`define TPW_CTRL_GIE_BIT  5
`define TPW_CTRL_ASYNC_BIT 6
`define TPW_CTRL_PS_LSB   8
`define TPW_FLAG_OVF_BIT  0
`define TPW_FLAG_CMP_BIT  1
`define TPW_IRQEN_OVF_BIT 0
`define TPW_IRQEN_CMP_BIT 1
`define TPW_GTC_PSR_BIT   1
`define TPW_GTC_TSM_BIT   7
`define TPW_WGM_PHASE     2'h1
`define TPW_COM_OFF       2'h0
`define TPW_COM_NONINV    2'h2
`define TPW_COM_INV       2'h3
`define TPW_COUNT_MAX     8'hff
`define TPW_COUNT_BOTTOM  8'h00
`define TPW_ASYNC_PSR_CYCLES 2
`endif

// ==== pkg/tpw_pkg.sv ====
// types shared by the pwm timer modules
package tpw_pkg;
    typedef enum logic [1:0] {
        TPW_BUS_IDLE,
        TPW_BUS_ACK,
        TPW_BUS_HOLD
    } tpw_bus_state_t;
    typedef enum logic {
        TPW_DIR_UP,
        TPW_DIR_DOWN
    } tpw_dir_t;
endpackage

// ==== core/tpw_prescaler.sv ====
// timer clock prescaler producing a one-cycle tick
`timescale 1ns/1ps
`include "tpw_cfg.svh"
module tpw_prescaler #(
    parameter int WIDTH = 10
) (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    // control
    input  wire logic       i_clear,
    input  wire logic [2:0] i_select,
    // tick out
    output logic            o_tick
);
    typedef struct packed {
        logic [WIDTH-1:0] count;
        logic             tick;
    } tpw_ps_state_t;

    tpw_ps_state_t state_q;
    tpw_ps_state_t state_d;

    initial begin
        if (WIDTH < 10) begin
            $error("prescaler width must be at least 10");
        end
    end

    function automatic logic tap(input logic [WIDTH-1:0] c, input logic [2:0] s);
        case (s)
            3'h1: tap = 1'b1;
            3'h2: tap = &c[2:0];
            3'h3: tap = &c[4:0];
            3'h4: tap = &c[5:0];
            3'h5: tap = &c[6:0];
            3'h6: tap = &c[7:0];
            3'h7: tap = &c[9:0];
            default: tap = 1'b0;
        endcase
    endfunction

    always_comb begin
        state_d = state_q;
        if (i_clear) begin
            state_d.count = '0;
            state_d.tick  = 1'b0;
        end else begin
            state_d.tick  = tap(state_q.count, i_select);
            state_d.count = state_q.count + {{(WIDTH-1){1'b0}}, 1'b1};
            if (state_d.tick) begin
                state_d.count = '0;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q <= '0;
        end else begin
            state_q <= state_d;
        end
    end

    assign o_tick = state_q.tick;
endmodule

// ==== core/tpw_wb_slave.sv ====
// classic wishbone handshake: one ack per request, ack dropped after one cycle
`timescale 1ns/1ps
`include "tpw_cfg.svh"
module tpw_wb_slave (
    // clock and reset
    input  wire logic i_clock,
    input  wire logic i_reset,
    // bus request
    input  wire logic i_cyc,
    input  wire logic i_stb,
    // access strobe and ack
    output logic      o_access,
    output logic      o_ack
);
    typedef struct packed {
        tpw_pkg::tpw_bus_state_t st;
    } tpw_wb_state_t;

    tpw_wb_state_t state_q;
    tpw_wb_state_t state_d;

    always_comb begin
        state_d = state_q;
        case (state_q.st)
            tpw_pkg::TPW_BUS_IDLE: begin
                if (i_cyc && i_stb) begin
                    state_d.st = tpw_pkg::TPW_BUS_ACK;
                end
            end
            tpw_pkg::TPW_BUS_ACK: begin
                state_d.st = tpw_pkg::TPW_BUS_HOLD;
            end
            tpw_pkg::TPW_BUS_HOLD: begin
                if (!(i_cyc && i_stb)) begin
                    state_d.st = tpw_pkg::TPW_BUS_IDLE;
                end
            end
            default: begin
                state_d.st = tpw_pkg::TPW_BUS_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            state_q.st <= tpw_pkg::TPW_BUS_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // access happens in the cycle o_ack is high; the timer registers it, so the master samples ack one cycle later
    assign o_ack    = (state_q.st == tpw_pkg::TPW_BUS_ACK);
    assign o_access = (state_q.st == tpw_pkg::TPW_BUS_ACK);
endmodule

// ==== sim/tpw_timer_chk.sv ====
// port checker for the pwm timer, bound to the timer top
`timescale 1ns/1ps
`include "tpw_cfg.svh"
module tpw_timer_chk #(
    parameter int PS_WIDTH = 10
) (
    // clock and reset
    input wire logic        i_clock,
    input wire logic        i_reset,
    // wishbone
    input wire logic        i_wb_cyc,
    input wire logic        i_wb_stb,
    input wire logic        i_wb_we,
    input wire logic [7:0]  i_wb_adr,
    input wire logic [3:0]  i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    input wire logic [31:0] o_wb_dat,
    input wire logic        o_wb_ack,
    // pin and irqs
    input wire logic        i_port_value,
    input wire logic        o_compare_out_pin,
    input wire logic        o_compare_out_pin_oe,
    input wire logic        o_compare_irq,
    input wire logic        o_overflow_irq
);
    logic gie_q;
    logic ddr_q;
    logic oen_q;
    logic cen_q;
    logic cmp_ok;
    logic ovf_ok;
    logic wr;
    logic rd_ack;
    assign wr     = i_wb_cyc && i_wb_stb && i_wb_we && o_wb_ack && i_wb_sel[0];
    assign rd_ack = o_wb_ack && !i_wb_we;
    assign cmp_ok = gie_q && cen_q;
    assign ovf_ok = gie_q && oen_q;
    // mirror of the enables written over the bus
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            gie_q <= 1'b0;
            ddr_q <= 1'b0;
            oen_q <= 1'b0;
            cen_q <= 1'b0;
        end else if (wr && i_wb_adr == `TPW_ADDR_CTRL) begin
            gie_q <= i_wb_dat[`TPW_CTRL_GIE_BIT];
            ddr_q <= i_wb_dat[`TPW_CTRL_DDR_BIT];
        end else if (wr && i_wb_adr == `TPW_ADDR_IRQEN) begin
            oen_q <= i_wb_dat[`TPW_IRQEN_OVF_BIT];
            cen_q <= i_wb_dat[`TPW_IRQEN_CMP_BIT];
        end
    end
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_reset);
    sequence s_req; $rose(i_wb_cyc && i_wb_stb); endsequence
    sequence s_ack2; !o_wb_ack ##1 !o_wb_ack ##1 o_wb_ack; endsequence
    property p_ack_lat; s_req |-> s_ack2; endproperty
    property p_ack_once; o_wb_ack |=> !o_wb_ack; endproperty
    property p_ack_req; o_wb_ack |-> i_wb_cyc && i_wb_stb; endproperty
    property p_flag_rsv; rd_ack && i_wb_adr == `TPW_ADDR_FLAGS |-> o_wb_dat[31:2] == 30'h0; endproperty
    property p_count_w; rd_ack && i_wb_adr == `TPW_ADDR_COUNT |-> o_wb_dat[31:8] == 24'h0; endproperty
    property p_cmp_irq; o_compare_irq |-> cmp_ok; endproperty
    property p_ovf_irq; o_overflow_irq |-> ovf_ok; endproperty
    property p_oe; o_compare_out_pin_oe |-> ddr_q; endproperty
    a_ack_lat: assert property (p_ack_lat) else $error("ack latency wrong");
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    a_ack_req: assert property (p_ack_req) else $error("ack without request");
    a_flag_rsv: assert property (p_flag_rsv) else $error("flag upper bits set");
    a_count_w: assert property (p_count_w) else $error("count wider than 8 bits");
    a_cmp_irq: assert property (p_cmp_irq) else $error("compare irq not enabled");
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq not enabled");
    a_oe: assert property (p_oe) else $error("pin driven while input");
endmodule

bind tpw_timer tpw_timer_chk #(.PS_WIDTH(PS_WIDTH)) u_chk (
    .i_clock(i_clock), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
    .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
    .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_port_value(i_port_value),
    .o_compare_out_pin(o_compare_out_pin), .o_compare_out_pin_oe(o_compare_out_pin_oe),
    .o_compare_irq(o_compare_irq), .o_overflow_irq(o_overflow_irq));

// ==== sim/tpw_timer_test.sv ====
// self-checking bench for the pwm timer
`timescale 1ns/1ps
`include "tpw_cfg.svh"
module tpw_timer_test;
    logic        i_clock;
    logic        i_reset;
    logic        i_wb_cyc;
    logic        i_wb_stb;
    logic        i_wb_we;
    logic [7:0]  i_wb_adr;
    logic [3:0]  i_wb_sel;
    logic [31:0] i_wb_dat;
    logic [31:0] o_wb_dat;
    logic        o_wb_ack;
    logic        i_port_value;
    logic        o_compare_out_pin;
    logic        o_compare_out_pin_oe;
    logic        o_compare_irq;
    logic        o_overflow_irq;
    int          mismatches = 0;
    int          n_tests = 0;
    int          cycles = 0;
    integer      seed;
    logic [31:0] q;
    logic [7:0]  c;
    logic [7:0]  adrs [7] = '{`TPW_ADDR_CTRL, `TPW_ADDR_COUNT, `TPW_ADDR_COMPARE,
                              `TPW_ADDR_FLAGS, `TPW_ADDR_IRQEN, `TPW_ADDR_GTC, 8'h1c};

    tpw_timer #(.PS_WIDTH(10)) i_tpw_timer (
        .i_clock(i_clock), .i_reset(i_reset), .i_wb_cyc(i_wb_cyc), .i_wb_stb(i_wb_stb),
        .i_wb_we(i_wb_we), .i_wb_adr(i_wb_adr), .i_wb_sel(i_wb_sel), .i_wb_dat(i_wb_dat),
        .o_wb_dat(o_wb_dat), .o_wb_ack(o_wb_ack), .i_port_value(i_port_value),
        .o_compare_out_pin(o_compare_out_pin), .o_compare_out_pin_oe(o_compare_out_pin_oe),
        .o_compare_irq(o_compare_irq), .o_overflow_irq(o_overflow_irq));

    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // hang guard
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            mismatches++;
            end_sim();
        end
    end

    task automatic end_sim();
        $display("tests %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            mismatches++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask

    // one classic wishbone cycle, read data left in q
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clock);
        i_wb_cyc <= 1'b1;
        i_wb_stb <= 1'b1;
        i_wb_we  <= w;
        i_wb_sel <= 4'h3;
        i_wb_adr <= a;
        i_wb_dat <= d;
        do @(posedge i_clock); while (o_wb_ack !== 1'b1);
        q = o_wb_dat;
        i_wb_cyc <= 1'b0;
        i_wb_stb <= 1'b0;
    endtask

    task automatic wait_irq(input logic cmp);
        int n;
        n = 0;
        while (((cmp ? o_compare_irq : o_overflow_irq) !== 1'b1) && n < 1200) begin
            @(posedge i_clock);
            n++;
        end
        chk("irq", 32'h1, {31'h0, cmp ? o_compare_irq : o_overflow_irq});
    endtask

    task automatic duty(input logic [31:0] e);
        logic [31:0] hi;
        hi = 32'h0;
        repeat (510) begin
            @(posedge i_clock);
            hi += {31'h0, o_compare_out_pin === 1'b1};
        end
        chk("duty", e, hi);
    endtask

    function automatic logic [31:0] ctl(input logic [2:0] ps, input logic [1:0] com,
                                        input logic gie);
        return {21'h0, ps, 2'h0, gie, 1'b1, com, `TPW_WGM_PHASE};
    endfunction

    function automatic logic [7:0] nxt(input logic [7:0] v, input logic u);
        if (v == `TPW_COUNT_MAX) return v - 8'h1;
        if (v == `TPW_COUNT_BOTTOM) return 8'h1;
        return u ? v + 8'h1 : v - 8'h1;
    endfunction

    initial begin
        logic [7:0] last;
        logic       up;
        logic       first;
        int         t0;
        int         turns;
        seed = 32'ha103;
        i_reset = 1'b1;
        i_wb_cyc = 1'b0;
        i_wb_stb = 1'b0;
        i_wb_we = 1'b0;
        i_wb_adr = 8'h0;
        i_wb_sel = 4'h3;
        i_wb_dat = 32'h0;
        i_port_value = 1'b0;
        repeat (8) @(posedge i_clock);
        i_reset <= 1'b0;
        for (int k = 0; k < 7; k++) begin
            wb(1'b0, adrs[k], 32'h0);
            chk("reset", 32'h0, q);
        end
        // port function while compare mode is off
        wb(1'b1, `TPW_ADDR_CTRL, 32'h1 << `TPW_CTRL_DDR_BIT);
        for (int k = 0; k < 4; k++) begin
            i_port_value <= 1'($random(seed));
            repeat (3) @(posedge i_clock);
            chk("pin", {31'h0, i_port_value}, {31'h0, o_compare_out_pin});
            chk("oe", 32'h1, {31'h0, o_compare_out_pin_oe});
        end
        wb(1'b1, `TPW_ADDR_CTRL, 32'h110);
        wb(1'b0, `TPW_ADDR_COUNT, 32'h0);
        last = q[7:0];
        wb(1'b0, `TPW_ADDR_COUNT, 32'h0);
        chk("still", {24'h0, last}, q);
        // dual slope sweep at /8
        wb(1'b1, `TPW_ADDR_CTRL, ctl(3'h2, `TPW_COM_OFF, 1'b0));
        turns = 0;
        first = 1'b1;
        t0 = cycles;
        up = 1'b1;
        while (turns < 3) begin
            wb(1'b0, `TPW_ADDR_COUNT, 32'h0);
            if (q[7:0] !== last) begin
                if (!first) chk("step", {24'h0, nxt(last, up)}, q);
                if (last == 8'hff) chk("max_hold", 32'h1, {31'h0, cycles - t0 < 12});
                if (last == 8'hff || last == 8'h00) turns++;
                up = q[7:0] > last;
                first = 1'b0;
                last = q[7:0];
                t0 = cycles;
            end
        end
        // flags and interrupts
        c = 8'h10 + 8'({$random(seed)} % 96);
        wb(1'b1, `TPW_ADDR_CTRL, ctl(3'h0, `TPW_COM_NONINV, 1'b0));
        wb(1'b1, `TPW_ADDR_COMPARE, {24'h0, c});
        wb(1'b1, `TPW_ADDR_IRQEN, 32'h3);
        wb(1'b1, `TPW_ADDR_FLAGS, 32'hff);
        wb(1'b0, `TPW_ADDR_FLAGS, 32'h0);
        chk("flags_clr", 32'h0, q);
        wb(1'b1, `TPW_ADDR_CTRL, ctl(3'h1, `TPW_COM_NONINV, 1'b1));
        wait_irq(1'b1);
        wb(1'b0, `TPW_ADDR_FLAGS, 32'h0);
        chk("cmp_flag", 32'h2, q & 32'h2);
        chk("flag_rsv", 32'h0, q & 32'hfffffffc);
        wb(1'b1, `TPW_ADDR_FLAGS, 32'h2);
        wb(1'b0, `TPW_ADDR_FLAGS, 32'h0);
        chk("cmp_w1c", 32'h0, q & 32'h2);
        wait_irq(1'b0);
        wb(1'b0, `TPW_ADDR_FLAGS, 32'h0);
        chk("ovf_flag", 32'h1, q & 32'h1);
        wb(1'b1, `TPW_ADDR_IRQEN, 32'h2);
        repeat (3) @(posedge i_clock);
        chk("ovf_mask", 32'h0, {31'h0, o_overflow_irq});
        wb(1'b1, `TPW_ADDR_IRQACK, 32'h1);
        wb(1'b0, `TPW_ADDR_FLAGS, 32'h0);
        chk("ovf_ack", 32'h0, q & 32'h1);
        // pwm duty, non-inverted then inverted
        repeat (510) @(posedge i_clock);
        duty({23'h0, c, 1'b0});
        wb(1'b1, `TPW_ADDR_CTRL, ctl(3'h1, `TPW_COM_INV, 1'b1));
        repeat (520) @(posedge i_clock);
        duty(32'd510 - {23'h0, c, 1'b0});
        // prescaler reset bit
        wb(1'b1, `TPW_ADDR_GTC, 32'h02);
        wb(1'b0, `TPW_ADDR_GTC, 32'h0);
        chk("psr", 32'h0, q);
        wb(1'b1, `TPW_ADDR_GTC, 32'h82);
        wb(1'b0, `TPW_ADDR_GTC, 32'h0);
        chk("psr_hold", 32'h82, q);
        wb(1'b1, `TPW_ADDR_GTC, 32'h0);
        wb(1'b0, `TPW_ADDR_GTC, 32'h0);
        chk("psr_rel", 32'h0, q);
        wb(1'b1, `TPW_ADDR_CTRL, 32'h150);
        wb(1'b1, `TPW_ADDR_GTC, 32'h02);
        wb(1'b0, `TPW_ADDR_GTC, 32'h0);
        chk("psr_async", 32'h0, q);
        end_sim();
    end
endmodule
